//--- bench/serial_peer.sv
// Far serial station that drives the receive line of the block.
`timescale 1ns/1ns
module serial_peer #(
	parameter int unsigned BIT_CYC = 1088
) (
	input  wire logic i_sys_clk, // System clock.
	output logic      o_line     // Line to the block, idle high.
);
	// The line rests at stop level between frames.
	initial o_line = 1'b1;
	// Each level is held a whole bit and changed just after an edge.
	task automatic hold_bit(input logic b);
		o_line = b;
		repeat (BIT_CYC) @(posedge i_sys_clk);
		#1;
	endtask
	// Start, eight bits from the lowest, optional parity, stop, then one idle bit.
	task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stop);
		hold_bit(1'b0);
		for (int k = 0; k < 8; k++) begin
			hold_bit(d[k]);
		end
		if (par_on) begin
			hold_bit(par);
		end
		hold_bit(stop);
		hold_bit(1'b1);
	endtask
	// A short low pulse gives line activity without a frame.
	task automatic blip();
		o_line = 1'b0;
		repeat (4) @(posedge i_sys_clk);
		#1;
		o_line = 1'b1;
	endtask
endmodule // serial_peer

//--- bench/tb_uart_irq_baud_shutdown.sv
// Self-checking bench for the interrupt, baud and power-down block.
`timescale 1ns/1ns
module tb_uart_irq_baud_shutdown;
	localparam int unsigned STARTUP = 20;
	logic        i_sys_clk, i_rst, i_cfg_write, i_cfg_powerdown, i_cfg_parity_enable, i_cfg_rts;
	logic        i_cfg_parity_mask, i_cfg_rx_data_mask, i_cfg_activity_mask, i_cfg_tx_empty_mask;
	logic        i_data_write, i_tx_parity_bit, i_data_read, i_powerdown_pin_n, i_rx, i_cts;
	logic [3:0]  i_cfg_baud, code;
	logic [7:0]  i_tx_data, o_rx_data_bits;
	logic        o_irq_n, o_rx_parity_flag, o_rx_data_avail, o_activity_or_frame_error_flag;
	logic        o_tx_empty, o_powerdown_status, o_osc_enable, o_rts, o_cts, o_tx, prev_avail;
	logic [8:0]  exp_q[$];
	logic [8:0]  lastw;
	logic [31:0] rnd = 32'h453b8aaf;
	int          mismatches, n_checks, cyc, w, ratio;

	uart_irq_baud_shutdown #(.STARTUP_CYCLES(STARTUP)) dut (.i_sys_clk, .i_rst, .i_cfg_write,
		.i_cfg_powerdown, .i_cfg_parity_enable, .i_cfg_baud, .i_cfg_parity_mask,
		.i_cfg_rx_data_mask, .i_cfg_activity_mask, .i_cfg_tx_empty_mask, .i_cfg_rts,
		.i_data_write, .i_tx_data, .i_tx_parity_bit, .i_data_read, .i_powerdown_pin_n, .i_rx,
		.i_cts, .o_irq_n, .o_rx_data_bits, .o_rx_parity_flag, .o_rx_data_avail,
		.o_activity_or_frame_error_flag, .o_tx_empty, .o_powerdown_status, .o_osc_enable,
		.o_rts, .o_cts, .o_tx);
	serial_peer peer (.i_sys_clk, .o_line(i_rx));

	// Clock of 4 ns period.
	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic done(input string what);
		$display("test %s finished", what);
	endtask
	// Masks are given as parity, data, activity, empty; RTS and CTS are random.
	task automatic cfg(input logic pd, input logic pe, input logic [3:0] cd, input logic [3:0] m);
		rnd = lfsr(rnd);
		{i_cfg_powerdown, i_cfg_parity_enable, i_cfg_baud} = {pd, pe, cd};
		{i_cfg_parity_mask, i_cfg_rx_data_mask, i_cfg_activity_mask, i_cfg_tx_empty_mask} = m;
		{i_cfg_rts, i_cts} = rnd[5:4];
		i_cfg_write = 1'b1;
		tick(1);
		i_cfg_write = 1'b0;
	endtask
	task automatic pulse_read();
		i_data_read = 1'b1;
		tick(1);
		i_data_read = 1'b0;
		tick(2);
	endtask
	task automatic send_word(input logic [7:0] d);
		{i_tx_data, i_tx_parity_bit} = {d, rnd[7]};
		i_data_write = 1'b1;
		tick(1);
		i_data_write = 1'b0;
	endtask
	// Counts cycles until the serial output reaches a level, bounded by lim.
	task automatic wait_tx(input logic lvl, input int lim, output int n);
		n = 0;
		while (o_tx !== lvl && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Each word that makes the data-available flag rise from low is matched against the oldest note.
	always @(posedge i_sys_clk) begin
		if (o_rx_data_avail === 1'b1 && prev_avail === 1'b0) begin
			if (exp_q.size() == 0) begin
				chk("unexpected_word", 16'h0000, 16'h0001);
			end else begin
				chk("rx_word", exp_q.pop_front(), {o_rx_parity_flag, o_rx_data_bits});
			end
		end
		prev_avail = o_rx_data_avail;
	end

	// A hang is cut short well above the length of the whole sequence.
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		{i_cfg_write, i_cfg_powerdown, i_cfg_parity_enable, i_cfg_baud, i_cfg_parity_mask,
			i_cfg_rx_data_mask, i_cfg_activity_mask, i_cfg_tx_empty_mask, i_cfg_rts,
			i_data_write, i_tx_data, i_tx_parity_bit, i_data_read, i_cts, prev_avail} = '0;
		{i_rst, i_powerdown_pin_n} = 2'b11;
		tick(12);
		i_rst = 1'b0;
		tick(1);
		chk("reset_out", 16'h003c, {o_irq_n, o_tx, o_tx_empty, o_osc_enable, o_powerdown_status,
			o_rx_data_avail});
		done("reset");
		// Parity on with bit one, on with bit zero, then off; the last word stays unread.
		for (int i = 0; i < 3; i++) begin
			cfg(1'b0, i < 2, 4'h0, {1'b1, i == 2, 2'b00});
			lastw = {(i < 2) && (i != 1), rnd[15:8]};
			exp_q.push_back(lastw);
			peer.send(rnd[15:8], i < 2, i != 1, 1'b1);
			chk("parity_irq", {15'h0, !lastw[8] && (i != 2)}, {15'h0, o_irq_n});
			if (i < 2) begin
				pulse_read();
				chk("read_pops", 16'h0001, {o_rx_data_avail, o_irq_n});
			end
		end
		done("receive");
		cfg(1'b0, 1'b0, 4'h0, 4'b0010);
		peer.send(rnd[23:16], 1'b0, 1'b0, 1'b0);
		chk("frame_error", 16'h0002, {o_activity_or_frame_error_flag, o_irq_n});
		chk("oldest_word", lastw, {o_rx_parity_flag, o_rx_data_bits});
		cfg(1'b0, 1'b0, 4'h0, 4'b0010);
		chk("error_cleared", 16'h0001, {o_activity_or_frame_error_flag, o_irq_n});
		done("framing");
		// A random slow or fast baud code; the first data bit is one, the rest zero.
		code = (rnd[1:0] == 2'h0) ? 4'h0 : (rnd[1:0] == 2'h1) ? 4'h1 : 4'h8;
		ratio = code[3] ? (3 << code[2:0]) : (1 << code[2:0]);
		cfg(1'b0, 1'b0, code, 4'b0001);
		send_word(8'h01);
		wait_tx(1'b0, 20, w);
		chk("tx_empty_irq", 16'h0002, {o_tx_empty, o_irq_n});
		wait_tx(1'b1, 16 * 68 * ratio + 20, w);
		wait_tx(1'b0, 16 * 68 * ratio + 20, w);
		chk("bit_cycles", 16'(16 * 68 * ratio), 16'(w));
		pulse_read();
		chk("tx_irq_cleared", 16'h0003, {o_tx_empty, o_irq_n});
		i_powerdown_pin_n = 1'b0;
		tick(2);
		chk("hard_down", 16'h0019, {o_tx, o_powerdown_status, o_osc_enable, o_rx_data_avail,
			o_tx_empty});
		done("transmit");
		cfg(1'b1, 1'b0, 4'h0, 4'b0010);
		tick(1);
		chk("rts_cts", {14'h0, i_cfg_rts, i_cts}, {14'h0, o_rts, o_cts});
		chk("quiet_down", 16'h0001, {o_activity_or_frame_error_flag, o_irq_n});
		peer.blip();
		tick(1);
		chk("activity", 16'h0002, {o_activity_or_frame_error_flag, o_irq_n});
		i_powerdown_pin_n = 1'b1;
		cfg(1'b0, 1'b0, 4'h0, 4'b0010);
		tick(1);
		chk("wake", {11'h0, 4'b0101, i_cfg_rts}, {11'h0, o_powerdown_status, o_osc_enable,
			o_activity_or_frame_error_flag, o_irq_n, o_rts});
		tick(STARTUP + 4);
		done("wake");
		// Soft request in mid-frame must wait for the whole frame, parity bit included.
		cfg(1'b0, 1'b1, 4'h0, 4'b0000);
		send_word(rnd[31:24]);
		wait_tx(1'b0, 20, w);
		cfg(1'b1, 1'b1, 4'h0, 4'b0000);
		w = 0;
		while (o_powerdown_status !== 1'b1 && w < 20000) begin
			tick(1);
			w++;
		end
		chk("drain_long", 16'h0001, {15'h0, w >= 10 * 1088});
		chk("drain_done", 16'h0005, {o_tx, o_osc_enable, o_powerdown_status});
		done("drain");
		chk("pending_words", 16'h0000, 16'(exp_q.size()));
		conclude();
	end
endmodule // tb_uart_irq_baud_shutdown

bind uart_irq_baud_shutdown uart_irq_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) props (
	.i_sys_clk, .i_rst, .i_cfg_write, .i_cfg_powerdown, .i_cfg_parity_mask, .i_cfg_rx_data_mask,
	.i_cfg_activity_mask, .i_cfg_tx_empty_mask, .i_cfg_rts, .i_powerdown_pin_n, .o_irq_n,
	.o_rx_data_bits, .o_rx_parity_flag, .o_rx_data_avail, .o_activity_or_frame_error_flag,
	.o_tx_empty, .o_powerdown_status, .o_osc_enable, .o_rts, .o_tx);

//--- bench/uart_irq_properties.sv
// Concurrent checks on the ports of the interrupt, baud and power-down block.
`timescale 1ns/1ns
module uart_irq_properties #(
	parameter int unsigned STARTUP_CYCLES = 20
) (
	input wire logic       i_sys_clk,           // Clock.
	input wire logic       i_rst,               // Reset, high.
	input wire logic       i_cfg_write,         // Config write.
	input wire logic       i_cfg_powerdown,     // Soft power-down bit.
	input wire logic       i_cfg_parity_mask,   // Parity mask.
	input wire logic       i_cfg_rx_data_mask,  // Data mask.
	input wire logic       i_cfg_activity_mask, // Activity mask.
	input wire logic       i_cfg_tx_empty_mask, // Empty mask.
	input wire logic       i_cfg_rts,           // RTS bit.
	input wire logic       i_powerdown_pin_n,   // Power-down pin.
	input wire logic       o_irq_n,             // Interrupt.
	input wire logic [7:0] o_rx_data_bits,      // Oldest word.
	input wire logic       o_rx_parity_flag,    // Parity flag.
	input wire logic       o_rx_data_avail,     // Data available.
	input wire logic       o_activity_or_frame_error_flag, // Activity or error.
	input wire logic       o_tx_empty,          // Buffer free.
	input wire logic       o_powerdown_status,  // Powered down.
	input wire logic       o_osc_enable,        // Oscillator on.
	input wire logic       o_rts,               // RTS out.
	input wire logic       o_tx                 // Serial out.
);
	logic [3:0] mask;
	// The masks live only inside the block, so a copy is kept from each write.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			mask <= 4'h0;
		end else if (i_cfg_write) begin
			mask <= {i_cfg_parity_mask, i_cfg_rx_data_mask, i_cfg_activity_mask, i_cfg_tx_empty_mask};
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// A busy transmitter must keep the block awake unless the pin forced it down.
	sequence soft_req_s;
		i_cfg_write && i_cfg_powerdown && !o_powerdown_status && !o_tx;
	endsequence
	sequence held_up_s;
		(!o_powerdown_status || !$past(i_powerdown_pin_n)) [*8];
	endsequence
	data_irq_a: assert property (mask[2] && o_rx_data_avail |-> !o_irq_n)
		else $error("data source did not raise interrupt");
	parity_irq_a: assert property (mask[3] && o_rx_parity_flag |-> !o_irq_n)
		else $error("parity source did not raise interrupt");
	error_irq_a: assert property (mask[1] && o_activity_or_frame_error_flag |-> !o_irq_n)
		else $error("activity source did not raise interrupt");
	tx_empty_irq_a: assert property (mask[0] && $rose(o_tx_empty) |-> !o_irq_n)
		else $error("empty buffer did not raise interrupt");
	quiet_irq_a: assert property (!(mask[3] && o_rx_parity_flag) && !mask[0] &&
		!(mask[2] && o_rx_data_avail) && !(mask[1] && o_activity_or_frame_error_flag) |-> o_irq_n)
		else $error("interrupt without enabled source");
	osc_off_a: assert property (o_powerdown_status |-> !o_osc_enable)
		else $error("oscillator runs in power-down");
	pin_down_a: assert property (!i_powerdown_pin_n |=> o_powerdown_status && o_tx)
		else $error("pin did not force power-down");
	entry_clear_a: assert property ($rose(o_powerdown_status) |-> !o_rx_data_avail &&
		o_tx_empty && !o_rx_parity_flag && o_rx_data_bits == 8'h00)
		else $error("power-down entry left state behind");
	wake_a: assert property (o_powerdown_status && i_cfg_write && !i_cfg_powerdown &&
		i_powerdown_pin_n |=> !o_powerdown_status && o_osc_enable && !o_rx_data_avail)
		else $error("wake write did not restart");
	soft_drain_a: assert property (soft_req_s |=> held_up_s)
		else $error("soft power-down cut a transmission");
	rts_write_a: assert property (i_cfg_write |=> o_rts == $past(i_cfg_rts))
		else $error("RTS not updated by write");
endmodule // uart_irq_properties

//--- verilog/baud_divider.sv
// Baud divider producing the sixteen-times oversampling tick from the baud code.
`timescale 1ns/1ns
module baud_divider (
	input  wire logic       i_sys_clk, // System clock.
	input  wire logic       i_rst,     // Synchronous reset, high.
	input  wire logic       i_run,     // Oscillator running and stable.
	input  wire logic [3:0] i_code,    // Baud divisor code.
	output logic            o_tick16   // One-cycle oversampling tick.
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} baud_s;

	baud_s       s;
	baud_s       next_s;
	logic [15:0] ratio;
	logic [15:0] period;

	// Low codes give powers of two, high codes three times a power of two.
	assign ratio  = {14'h0000, i_code[3], 1'b1} << i_code[2:0];
	assign period = ratio * uart_irq_pkg::OSC_PRESCALE;

	// The counter restarts whenever the oscillator is stopped.
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (!i_run) begin
			next_s.cnt = 16'h0000;
		end else if (s.cnt >= period - 16'h0001) begin
			next_s.cnt = 16'h0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_tick16 = s.tick;
endmodule // baud_divider

//--- verilog/uart_irq_baud_shutdown.sv
// Interrupt sources, receive queue, transmitter and power-down sequencing of the UART.
`timescale 1ns/1ns
module uart_irq_baud_shutdown #(
	parameter int unsigned STARTUP_CYCLES = uart_irq_pkg::STARTUP_CYCLES
) (
	input  wire logic       i_sys_clk,           // System clock, 250 MHz.
	input  wire logic       i_rst,               // Synchronous reset, high.
	input  wire logic       i_cfg_write,         // Configuration write done, pulse.
	input  wire logic       i_cfg_powerdown,     // Soft power-down request bit.
	input  wire logic       i_cfg_parity_enable, // Parity on.
	input  wire logic [3:0] i_cfg_baud,          // Baud divisor code.
	input  wire logic       i_cfg_parity_mask,   // Parity interrupt enable.
	input  wire logic       i_cfg_rx_data_mask,  // Data-available interrupt enable.
	input  wire logic       i_cfg_activity_mask, // Activity or error interrupt enable.
	input  wire logic       i_cfg_tx_empty_mask, // Transmit-empty interrupt enable.
	input  wire logic       i_cfg_rts,           // RTS level to drive.
	input  wire logic       i_data_write,        // Data write done, pulse.
	input  wire logic [7:0] i_tx_data,           // Word to transmit.
	input  wire logic       i_tx_parity_bit,     // Parity bit to transmit.
	input  wire logic       i_data_read,         // Data read done, pulse.
	input  wire logic       i_powerdown_pin_n,   // Hardware power-down, low.
	input  wire logic       i_rx,                // Serial receive line.
	input  wire logic       i_cts,               // CTS input level.
	output logic            o_irq_n,             // Interrupt request, low.
	output logic [7:0]      o_rx_data_bits,      // Oldest received word.
	output logic            o_rx_parity_flag,    // Parity flag of oldest word.
	output logic            o_rx_data_avail,     // Unread data exists.
	output logic            o_activity_or_frame_error_flag, // Activity or error.
	output logic            o_tx_empty,          // Transmit buffer free.
	output logic            o_powerdown_status,  // In power-down.
	output logic            o_osc_enable,        // Oscillator running.
	output logic            o_rts,               // RTS output.
	output logic            o_cts,               // CTS read-back.
	output logic            o_tx                 // Serial transmit line.
);
	typedef struct packed {
		uart_irq_pkg::pwr_e              pwr;
		logic [uart_irq_pkg::START_CNT_W-1:0] start_cnt;
		logic                            parity_int_enable;
		logic                            rx_data_int_enable;
		logic                            activity_int_enable;
		logic                            tx_empty_int_enable;
		logic                            parity_enable;
		logic [3:0]                      baud_divisor_code;
		logic                            rts;
		logic                            cts;
		logic                            baud_run;
		uart_irq_pkg::rx_e               rx;
		logic [3:0]                      rx_tick;
		logic [3:0]                      rx_bit;
		logic [8:0]                      rx_sh;
		logic                            rx_prev;
		logic                            activity_or_frame_error_flag;
		logic [uart_irq_pkg::RXQ_DEPTH-1:0][8:0] q;
		logic [2:0]                      rd;
		logic [2:0]                      wr;
		logic [3:0]                      cnt;
		logic [7:0]                      rx_data_bits;
		logic                            rx_parity_flag;
		logic                            avail;
		logic [8:0]                      tx_buf;
		logic                            tx_full;
		logic                            tx_busy;
		logic [10:0]                     tx_sh;
		logic [3:0]                      tx_bit;
		logic [3:0]                      tx_tick;
		logic                            tx_line;
		logic                            tx_empty;
		logic                            tx_pend;
		logic                            irq_n;
		logic                            pd_status;
		logic                            osc_en;
	} state_s;

	state_s s;
	state_s next_s;
	logic   tick16;

	// Quiet state used both at reset and by the wake-up write.
	function automatic state_s quiet_state();
		state_s q;
		q = '0;
		q.pwr = uart_irq_pkg::PWR_RUN;
		q.rx = uart_irq_pkg::RX_IDLE;
		q.baud_divisor_code = uart_irq_pkg::BAUD_CODE_RST;
		q.baud_run = 1'b1;
		q.rx_prev = 1'b1;
		q.tx_line = 1'b1;
		q.tx_empty = 1'b1;
		q.irq_n = 1'b1;
		q.osc_en = 1'b1;
		return q;
	endfunction

	baud_divider u_baud (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_run     (s.baud_run),
		.i_code    (s.baud_divisor_code),
		.o_tick16  (tick16)
	);

	// One pass computes the whole next state; power handling comes last so its
	// clears override whatever the datapath did in the same cycle.
	always_comb begin
		logic       running;
		logic       push;
		logic       pop;
		logic       enter_down;
		logic       wake;
		logic [8:0] word;
		logic [3:0] rx_last;
		logic [3:0] tx_last;
		running = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		enter_down = 1'b0;
		wake = 1'b0;
		word = 9'h000;
		rx_last = 4'h0;
		tx_last = 4'h0;
		next_s = s;
		next_s.cts = i_cts;
		next_s.rx_prev = i_rx;
		running = (s.pwr == uart_irq_pkg::PWR_RUN) || (s.pwr == uart_irq_pkg::PWR_DRAIN);
		rx_last = s.parity_enable ? uart_irq_pkg::RX_LAST_PAR : uart_irq_pkg::RX_LAST_NOPAR;
		tx_last = s.parity_enable ? uart_irq_pkg::TX_LAST_PAR : uart_irq_pkg::TX_LAST_NOPAR;

		// Configuration fields load in every power state, so software can set up
		// the link while asleep.
		if (i_cfg_write) begin
			next_s.parity_int_enable = i_cfg_parity_mask;
			next_s.rx_data_int_enable = i_cfg_rx_data_mask;
			next_s.activity_int_enable = i_cfg_activity_mask;
			next_s.tx_empty_int_enable = i_cfg_tx_empty_mask;
			next_s.parity_enable = i_cfg_parity_enable;
			next_s.baud_divisor_code = i_cfg_baud;
			next_s.rts = i_cfg_rts;
			if (running) begin
				next_s.activity_or_frame_error_flag = 1'b0;
			end
		end

		// Receiver, sampling in the middle of each bit.
		if (running && tick16) begin
			case (s.rx)
				uart_irq_pkg::RX_IDLE: begin
					if (!i_rx) begin
						next_s.rx = uart_irq_pkg::RX_START;
						next_s.rx_tick = 4'h0;
					end
				end
				uart_irq_pkg::RX_START: begin
					if (s.rx_tick == uart_irq_pkg::HALF_BIT) begin
						next_s.rx_tick = 4'h0;
						next_s.rx_bit = 4'h0;
						next_s.rx = i_rx ? uart_irq_pkg::RX_IDLE : uart_irq_pkg::RX_DATA;
					end else begin
						next_s.rx_tick = s.rx_tick + 4'h1;
					end
				end
				uart_irq_pkg::RX_DATA: begin
					if (s.rx_tick == uart_irq_pkg::LAST_TICK) begin
						next_s.rx_sh = {i_rx, s.rx_sh[8:1]};
						next_s.rx_bit = s.rx_bit + 4'h1;
						if (s.rx_bit == rx_last) begin
							next_s.rx = uart_irq_pkg::RX_STOP;
						end
					end
					next_s.rx_tick = s.rx_tick + 4'h1;
				end
				uart_irq_pkg::RX_STOP: begin
					if (s.rx_tick == uart_irq_pkg::LAST_TICK) begin
						next_s.rx = uart_irq_pkg::RX_IDLE;
						if (!i_rx) begin
							next_s.activity_or_frame_error_flag = 1'b1;
						end else begin
							next_s.activity_or_frame_error_flag = 1'b0;
							push = 1'b1;
						end
					end
					next_s.rx_tick = s.rx_tick + 4'h1;
				end
				default: begin
					next_s.rx = uart_irq_pkg::RX_IDLE;
				end
			endcase
		end

		// A framed word goes to the queue without its framing status.
		if (s.parity_enable) begin
			word = {s.rx_sh[8], s.rx_sh[7:0]};
		end else begin
			word = {1'b0, s.rx_sh[8:1]};
		end
		if (push && (s.cnt != uart_irq_pkg::RXQ_FULL)) begin
			next_s.q[s.wr] = word;
			next_s.wr = s.wr + 3'h1;
		end else begin
			push = 1'b0;
		end
		pop = i_data_read && (s.cnt != 4'h0);
		if (pop) begin
			next_s.rd = s.rd + 3'h1;
		end
		next_s.cnt = s.cnt + {3'h0, push} - {3'h0, pop};

		// Transmitter: buffer feeds the shift register, line idles high.
		if (i_data_write && running && !s.tx_full) begin
			next_s.tx_buf = {i_tx_parity_bit, i_tx_data};
			next_s.tx_full = 1'b1;
		end
		if (running && !s.tx_busy && s.tx_full) begin
			if (s.parity_enable) begin
				next_s.tx_sh = {1'b1, s.tx_buf, 1'b0};
			end else begin
				next_s.tx_sh = {2'b11, s.tx_buf[7:0], 1'b0};
			end
			next_s.tx_line = 1'b0;
			next_s.tx_busy = 1'b1;
			next_s.tx_full = 1'b0;
			next_s.tx_bit = 4'h0;
			next_s.tx_tick = 4'h0;
		end else if (running && s.tx_busy && tick16) begin
			next_s.tx_tick = s.tx_tick + 4'h1;
			if (s.tx_tick == uart_irq_pkg::LAST_TICK) begin
				next_s.tx_bit = s.tx_bit + 4'h1;
				next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
				next_s.tx_line = s.tx_sh[1];
				if (s.tx_bit == tx_last) begin
					next_s.tx_busy = 1'b0;
					next_s.tx_line = 1'b1;
				end
			end
		end

		// Power sequencing.
		case (s.pwr)
			uart_irq_pkg::PWR_RUN: begin
				if (i_cfg_write && i_cfg_powerdown) begin
					next_s.pwr = uart_irq_pkg::PWR_DRAIN;
				end
			end
			uart_irq_pkg::PWR_DRAIN: begin
				if (i_cfg_write && !i_cfg_powerdown) begin
					next_s.pwr = uart_irq_pkg::PWR_RUN;
				end else if (!s.tx_full && !s.tx_busy && !next_s.tx_full) begin
					enter_down = 1'b1;
				end
			end
			uart_irq_pkg::PWR_DOWN: begin
				if (i_rx != s.rx_prev) begin
					next_s.activity_or_frame_error_flag = 1'b1;
				end
				if (i_cfg_write && !i_cfg_powerdown && i_powerdown_pin_n) begin
					wake = 1'b1;
				end
			end
			uart_irq_pkg::PWR_START: begin
				if (s.start_cnt >= STARTUP_CYCLES[uart_irq_pkg::START_CNT_W-1:0] - 1'b1) begin
					next_s.pwr = uart_irq_pkg::PWR_RUN;
				end else begin
					next_s.start_cnt = s.start_cnt + 1'b1;
				end
			end
			default: begin
				enter_down = 1'b1;
			end
		endcase
		if (!i_powerdown_pin_n && (s.pwr != uart_irq_pkg::PWR_DOWN)) begin
			enter_down = 1'b1;
		end

		// Entry into power-down flushes the receive side and the transmitter.
		if (enter_down) begin
			next_s.pwr = uart_irq_pkg::PWR_DOWN;
			next_s.rx = uart_irq_pkg::RX_IDLE;
			next_s.rx_sh = 9'h000;
			next_s.q = '0;
			next_s.rd = 3'h0;
			next_s.wr = 3'h0;
			next_s.cnt = 4'h0;
			next_s.activity_or_frame_error_flag = 1'b0;
			next_s.tx_buf = 9'h000;
			next_s.tx_full = 1'b0;
			next_s.tx_busy = 1'b0;
			next_s.tx_sh = 11'h7ff;
			next_s.tx_line = 1'b1;
		end

		// The wake-up write starts from the quiet state but keeps RTS, CTS and
		// the configuration it carries.
		if (wake) begin
			next_s = quiet_state();
			next_s.pwr = uart_irq_pkg::PWR_START;
			next_s.rts = i_cfg_rts;
			next_s.cts = i_cts;
			next_s.rx_prev = i_rx;
			next_s.parity_int_enable = i_cfg_parity_mask;
			next_s.rx_data_int_enable = i_cfg_rx_data_mask;
			next_s.activity_int_enable = i_cfg_activity_mask;
			next_s.tx_empty_int_enable = i_cfg_tx_empty_mask;
			next_s.parity_enable = i_cfg_parity_enable;
			next_s.baud_divisor_code = i_cfg_baud;
		end

		// Flags and outputs follow from the state just computed.
		next_s.avail = (next_s.cnt != 4'h0);
		if (next_s.avail) begin
			next_s.rx_data_bits = next_s.q[next_s.rd][7:0];
			next_s.rx_parity_flag = next_s.q[next_s.rd][8];
		end else begin
			next_s.rx_data_bits = 8'h00;
			next_s.rx_parity_flag = 1'b0;
		end
		next_s.tx_empty = !next_s.tx_full;
		// A read clears the pending source, but a new empty edge still wins.
		if (i_data_read) begin
			next_s.tx_pend = 1'b0;
		end
		if (next_s.tx_empty && !s.tx_empty) begin
			next_s.tx_pend = 1'b1;
		end
		next_s.pd_status = (next_s.pwr == uart_irq_pkg::PWR_DOWN);
		next_s.osc_en = (next_s.pwr != uart_irq_pkg::PWR_DOWN);
		next_s.baud_run = (next_s.pwr == uart_irq_pkg::PWR_RUN)
			|| (next_s.pwr == uart_irq_pkg::PWR_DRAIN);
		// Level sources reassert after a read if their condition still holds.
		next_s.irq_n = !((next_s.parity_int_enable && next_s.rx_parity_flag)
			|| (next_s.rx_data_int_enable && next_s.avail)
			|| (next_s.activity_int_enable && next_s.activity_or_frame_error_flag)
			|| (next_s.tx_empty_int_enable && next_s.tx_pend));
	end

	// State register.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			s <= quiet_state();
		end else begin
			s <= next_s;
		end
	end

	// Every output is a field of the state register.
	assign o_irq_n = s.irq_n;
	assign o_rx_data_bits = s.rx_data_bits;
	assign o_rx_parity_flag = s.rx_parity_flag;
	assign o_rx_data_avail = s.avail;
	assign o_activity_or_frame_error_flag = s.activity_or_frame_error_flag;
	assign o_tx_empty = s.tx_empty;
	assign o_powerdown_status = s.pd_status;
	assign o_osc_enable = s.osc_en;
	assign o_rts = s.rts;
	assign o_cts = s.cts;
	assign o_tx = s.tx_line;
endmodule // uart_irq_baud_shutdown

//--- verilog/uart_irq_pkg.sv
// Constants, state encodings and timing figures of the UART interrupt and power block.
package uart_irq_pkg;
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned STARTUP_TIME_MS = 25;
	localparam int unsigned STARTUP_CYCLES  = STARTUP_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned START_CNT_W     = 23;
	// System clocks per nominal crystal cycle; the crystal itself is modelled by this.
	localparam logic [15:0] OSC_PRESCALE    = 16'h0044;
	localparam logic [3:0]  HALF_BIT        = 4'h7;
	localparam logic [3:0]  LAST_TICK       = 4'hf;
	localparam logic [3:0]  RX_LAST_NOPAR   = 4'h7;
	localparam logic [3:0]  RX_LAST_PAR     = 4'h8;
	localparam logic [3:0]  TX_LAST_NOPAR   = 4'h9;
	localparam logic [3:0]  TX_LAST_PAR     = 4'ha;
	localparam int unsigned RXQ_DEPTH       = 8;
	localparam logic [3:0]  RXQ_FULL        = 4'h8;
	localparam logic [3:0]  BAUD_CODE_RST   = 4'h0;
	typedef enum logic [3:0] {
		PWR_RUN   = 4'h1,
		PWR_DRAIN = 4'h2,
		PWR_DOWN  = 4'h4,
		PWR_START = 4'h8
	} pwr_e;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rx_e;
endpackage
